// ---- hw/uart9_core.sv ----
// Nine-bit asynchronous serial port with multiprocessor filter and address recognition.
`timescale 1ns/1ps

module uart9_core
  import uart9_pkg::*;
#(
  parameter int unsigned SLOW_DIV = 2
) (
  // Clock, reset and clock enable
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // Configuration and rate source
  input wire serial_cfg_t cfg_i,
  input wire logic timer1_ovf_i,
  // Transmit buffer write
  input wire logic buf_wr_i,
  input wire logic [7:0] buf_wdata_i,
  input wire logic tx_ninth_bit_i,
  // Address and mask register writes
  input wire logic addr_wr_i,
  input wire logic [7:0] addr_wdata_i,
  input wire logic mask_wr_i,
  input wire logic [7:0] mask_wdata_i,
  // Flag clears
  input wire logic rx_done_clr_i,
  input wire logic tx_done_clr_i,
  // Serial lines
  input wire logic rxd_i,
  output logic txd_o,
  // Status and received data
  output rx_frame_t rx_frame_o,
  output logic rx_done_flag_o,
  output logic tx_done_flag_o,
  output logic tx_busy_o,
  output logic [7:0] slave_address_o,
  output logic [7:0] slave_address_mask_o
);

  if (SYNC_STAGES != 3) begin : g_check
    $error("receive synchroniser must have three stages");
  end

  // Reset release synchroniser; the rest of the block uses rst_n.
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  logic tick;

  uart9_rate_gen #(
    .SLOW_DIV(SLOW_DIV)
  ) u_rate (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .clk_en_i(clk_en_i),
    .var_rate_i(cfg_i.var_rate),
    .half_rate_i(cfg_i.half_rate),
    .timer1_ovf_i(timer1_ovf_i),
    .tick_o(tick)
  );

  // Address and mask registers.
  logic [7:0] slave_address_reg_q;
  logic [7:0] slave_address_reg_d;
  logic [7:0] slave_address_mask_reg_q;
  logic [7:0] slave_address_mask_reg_d;

  always_comb begin
    slave_address_reg_d = addr_wr_i ? addr_wdata_i : slave_address_reg_q;
    slave_address_mask_reg_d = mask_wr_i ? mask_wdata_i : slave_address_mask_reg_q;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      slave_address_reg_q <= ADDR_RESET;
      slave_address_mask_reg_q <= ADDR_RESET;
    end else if (clk_en_i) begin
      slave_address_reg_q <= slave_address_reg_d;
      slave_address_mask_reg_q <= slave_address_mask_reg_d;
    end
  end

  assign slave_address_o = slave_address_reg_q;
  assign slave_address_mask_o = slave_address_mask_reg_q;

  // Transmitter. Its divide-by-16 counter runs free so bit times are tied
  // to the counter, not to the moment of the buffer write.
  tx_state_t tx_state_q;
  tx_state_t tx_state_d;
  logic [3:0] tx_cnt_q;
  logic [3:0] tx_cnt_d;
  logic [8:0] tx_sr_q;
  logic [8:0] tx_sr_d;
  logic tx_first_q;
  logic tx_first_d;
  logic txd_q;
  logic txd_d;
  logic tx_roll;
  logic tx_done_set;

  always_comb begin
    tx_state_d = tx_state_q;
    tx_sr_d = tx_sr_q;
    tx_first_d = tx_first_q;
    tx_done_set = 1'b0;
    tx_cnt_d = tick ? tx_cnt_q + CNT_ONE : tx_cnt_q;
    tx_roll = tick && (tx_cnt_q == CNT_LAST);
    case (tx_state_q)
      TX_IDLE: begin
        // A write while a frame is in flight is ignored.
        if (buf_wr_i) begin
          // The ten-bit format puts a stop level where the ninth bit would be.
          tx_sr_d = {cfg_i.ten_bit ? STOP_LEVEL : tx_ninth_bit_i, buf_wdata_i};
          tx_state_d = TX_WAIT;
        end
      end
      TX_WAIT: begin
        if (tx_roll) begin
          tx_state_d = TX_START;
          tx_first_d = 1'b1;
        end
      end
      TX_START: begin
        if (tx_roll) begin
          tx_state_d = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_roll) begin
          if (!tx_first_q && (tx_sr_q[8:2] == SR_ZERO[8:2]) && tx_sr_q[1]) begin
            tx_sr_d = {SHIFT_FILL, tx_sr_q[8:1]};
            tx_state_d = TX_IDLE;
            tx_done_set = 1'b1;
          end else begin
            tx_sr_d = {tx_first_q ? STOP_LEVEL : SHIFT_FILL, tx_sr_q[8:1]};
            tx_first_d = 1'b0;
          end
        end
      end
      default: begin
        tx_state_d = TX_IDLE;
      end
    endcase
    case (tx_state_d)
      TX_START: txd_d = START_LEVEL;
      TX_DATA: txd_d = tx_sr_d[0];
      default: txd_d = IDLE_LEVEL;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_q <= TX_IDLE;
      tx_cnt_q <= CNT_ZERO;
      tx_sr_q <= SR_ZERO;
      tx_first_q <= 1'b0;
      txd_q <= IDLE_LEVEL;
    end else if (clk_en_i) begin
      tx_state_q <= tx_state_d;
      tx_cnt_q <= tx_cnt_d;
      tx_sr_q <= tx_sr_d;
      tx_first_q <= tx_first_d;
      txd_q <= txd_d;
    end
  end

  assign txd_o = txd_q;
  assign tx_busy_o = (tx_state_q != TX_IDLE);

  // Receive pin synchroniser. The filtered level moves only when the second
  // and third stages agree, which also hides a one-clock glitch.
  logic [2:0] sync_q;
  logic rx_level_q;
  logic rx_level_d;
  logic rx_fall;

  always_comb begin
    rx_level_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : rx_level_q;
    rx_fall = rx_level_q && !rx_level_d;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= {SYNC_STAGES{IDLE_LEVEL}};
      rx_level_q <= IDLE_LEVEL;
    end else if (clk_en_i) begin
      sync_q <= {sync_q[1:0], rxd_i};
      rx_level_q <= rx_level_d;
    end
  end

  // Receiver.
  rx_state_t rx_state_q;
  rx_state_t rx_state_d;
  logic [3:0] rx_cnt_q;
  logic [3:0] rx_cnt_d;
  logic [8:0] rx_sr_q;
  logic [8:0] rx_sr_d;
  logic [1:0] samp_q;
  logic [1:0] samp_d;
  logic rx_first_q;
  logic rx_first_d;
  rx_frame_t frame_q;
  rx_frame_t frame_d;
  logic rx_done_set;
  logic vote;
  logic [8:0] shifted;
  logic [7:0] rx_byte;
  logic addr_hit;
  logic accept;

  always_comb begin
    vote = vote3(samp_q[1], samp_q[0], rx_level_q);
    shifted = {rx_sr_q[7:0], vote};
    // Bits arrive LSB first into a left-shifting register, so the byte is
    // stored reversed and is turned round when it is loaded.
    rx_byte = reverse8(shifted[8:1]);
  end

  uart9_addr_match u_match (
    .slave_address_i(slave_address_reg_q),
    .slave_address_mask_i(slave_address_mask_reg_q),
    .rx_byte_i(rx_byte),
    .match_o(addr_hit)
  );

  always_comb begin
    // Ten-bit format: the filter only asks for a valid stop bit.
    accept = !rx_done_flag_o &&
             (!cfg_i.multiproc_enable ||
              (shifted[0] && (cfg_i.ten_bit || addr_hit)));
    rx_state_d = rx_state_q;
    rx_cnt_d = rx_cnt_q;
    rx_sr_d = rx_sr_q;
    samp_d = samp_q;
    rx_first_d = rx_first_q;
    frame_d = frame_q;
    rx_done_set = 1'b0;
    case (rx_state_q)
      RX_HUNT: begin
        if (cfg_i.rx_enable && rx_fall) begin
          rx_cnt_d = CNT_ZERO;
          rx_sr_d = RX_SR_INIT;
          rx_first_d = 1'b1;
          rx_state_d = RX_BITS;
        end
      end
      RX_BITS: begin
        if (tick) begin
          rx_cnt_d = rx_cnt_q + CNT_ONE;
          if (rx_cnt_q == SAMPLE_A) begin
            samp_d[1] = rx_level_q;
          end
          if (rx_cnt_q == SAMPLE_B) begin
            samp_d[0] = rx_level_q;
          end
          if (rx_cnt_q == SAMPLE_C) begin
            if (rx_first_q && vote) begin
              rx_state_d = RX_HUNT;
            end else if (!rx_first_q && !rx_sr_q[8]) begin
              rx_sr_d = shifted;
              rx_state_d = RX_TAIL;
              if (accept) begin
                frame_d.serial_buffer = rx_byte;
                frame_d.rx_ninth_bit = shifted[0];
                rx_done_set = 1'b1;
              end
            end else begin
              rx_sr_d = shifted;
              rx_first_d = 1'b0;
            end
          end
        end
      end
      RX_TAIL: begin
        if (tick) begin
          rx_cnt_d = rx_cnt_q + CNT_ONE;
          if (rx_cnt_q == SAMPLE_C) begin
            rx_state_d = RX_HUNT;
          end
        end
      end
      default: begin
        rx_state_d = RX_HUNT;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_q <= RX_HUNT;
      rx_cnt_q <= CNT_ZERO;
      rx_sr_q <= RX_SR_INIT;
      samp_q <= 2'h3;
      rx_first_q <= 1'b0;
      frame_q <= '0;
    end else if (clk_en_i) begin
      rx_state_q <= rx_state_d;
      rx_cnt_q <= rx_cnt_d;
      rx_sr_q <= rx_sr_d;
      samp_q <= samp_d;
      rx_first_q <= rx_first_d;
      frame_q <= frame_d;
    end
  end

  assign rx_frame_o = frame_q;

  // Done flags: a set in the same cycle as a clear wins, so no event is lost.
  logic rx_done_q;
  logic rx_done_d;
  logic tx_done_q;
  logic tx_done_d;

  always_comb begin
    rx_done_d = (rx_done_q && !rx_done_clr_i) || rx_done_set;
    tx_done_d = (tx_done_q && !tx_done_clr_i) || tx_done_set;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_done_q <= 1'b0;
      tx_done_q <= 1'b0;
    end else if (clk_en_i) begin
      rx_done_q <= rx_done_d;
      tx_done_q <= tx_done_d;
    end
  end

  assign rx_done_flag_o = rx_done_q;
  assign tx_done_flag_o = tx_done_q;

endmodule

// ---- pkg/uart9_pkg.sv ----
// Shared constants, carrier types and helper functions for the nine-bit serial port.
package uart9_pkg;

  // Oversampling counter: one bit time is sixteen ticks.
  localparam int unsigned CNT_W = 4;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_A = 4'h7;
  localparam logic [3:0] SAMPLE_B = 4'h8;
  localparam logic [3:0] SAMPLE_C = 4'h9;

  // Shift register widths and reset images.
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SR_W = 9;
  localparam logic [8:0] RX_SR_INIT = 9'h1FF;
  localparam logic [8:0] SR_ZERO = 9'h000;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Line levels.
  localparam logic IDLE_LEVEL = 1'b1;
  localparam logic START_LEVEL = 1'b0;
  localparam logic STOP_LEVEL = 1'b1;
  localparam logic SHIFT_FILL = 1'b0;

  // Input synchroniser depth for the receive pin.
  localparam int unsigned SYNC_STAGES = 3;

  typedef struct packed {
    logic var_rate;
    logic half_rate;
    logic ten_bit;
    logic multiproc_enable;
    logic rx_enable;
  } serial_cfg_t;

  typedef struct packed {
    logic [7:0] serial_buffer;
    logic rx_ninth_bit;
  } rx_frame_t;

  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_START, TX_DATA} tx_state_t;
  typedef enum logic [1:0] {RX_HUNT, RX_BITS, RX_TAIL} rx_state_t;

  function automatic logic vote3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic [7:0] reverse8(input logic [7:0] v);
    logic [7:0] r;
    r = BYTE_ZERO;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

endpackage

// ---- hw/uart9_rate_gen.sv ----
// Sixteen-times bit-rate tick generator for the fixed and variable rate modes.
`timescale 1ns/1ps
module uart9_rate_gen
  import uart9_pkg::*;
#(
  parameter int unsigned SLOW_DIV = 2
) (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // Rate selection
  input wire logic var_rate_i,
  input wire logic half_rate_i,
  input wire logic timer1_ovf_i,
  // Oversampling tick
  output logic tick_o
);

  localparam int unsigned DIV_W = (SLOW_DIV > 1) ? $clog2(SLOW_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SLOW_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;

  if (SLOW_DIV < 2) begin : g_check
    $error("SLOW_DIV must be at least 2");
  end

  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;

  // Fixed rate: tick every clock (bit rate 1/16) or every SLOW_DIV clocks (1/32 with SLOW_DIV of 2).
  // Variable rate: every timer 1 overflow pulse is one tick.
  always_comb begin
    div_d = (div_q == DIV_LAST) ? DIV_ZERO : div_q + DIV_W'(1);
    if (var_rate_i) begin
      tick_o = timer1_ovf_i;
    end else if (half_rate_i) begin
      tick_o = (div_q == DIV_LAST);
    end else begin
      tick_o = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= DIV_ZERO;
    end else if (clk_en_i) begin
      div_q <= div_d;
    end
  end

endmodule

// ---- hw/uart9_addr_match.sv ----
// Given and broadcast address comparison for automatic address recognition.
`timescale 1ns/1ps
module uart9_addr_match
  import uart9_pkg::*;
(
  // Address registers
  input wire logic [7:0] slave_address_i,
  input wire logic [7:0] slave_address_mask_i,
  // Received byte
  input wire logic [7:0] rx_byte_i,
  // Result
  output logic match_o
);

  logic given_hit;
  logic bcast_hit;
  logic [7:0] bcast;

  always_comb begin
    // Mask zeros are don't-care in the given address.
    given_hit = ((rx_byte_i ^ slave_address_i) & slave_address_mask_i) == BYTE_ZERO;
    // Zeros of the OR are don't-care; ones must be received as ones.
    bcast = slave_address_i | slave_address_mask_i;
    bcast_hit = (rx_byte_i & bcast) == bcast;
    match_o = given_hit | bcast_hit;
  end

endmodule

// ---- sim/uart9_core_chk.sv ----
// Concurrent checks on the ports of the nine-bit serial port core.
`timescale 1ns/1ps
module uart9_core_chk
  import uart9_pkg::*;
#(
  parameter int unsigned SLOW_DIV = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Watched inputs
  input wire logic clk_en_i,
  input wire logic buf_wr_i,
  input wire logic addr_wr_i,
  input wire logic [7:0] addr_wdata_i,
  input wire logic mask_wr_i,
  input wire logic [7:0] mask_wdata_i,
  input wire logic rx_done_clr_i,
  // Watched outputs
  input wire logic txd_o,
  input wire rx_frame_t rx_frame_o,
  input wire logic rx_done_flag_o,
  input wire logic tx_done_flag_o,
  input wire logic tx_busy_o,
  input wire logic [7:0] slave_address_o,
  input wire logic [7:0] slave_address_mask_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_addr_clear: assert property (
    $rose(reset_n_i) |-> slave_address_o == 8'h00 && slave_address_mask_o == 8'h00)
    else $error("address or mask not clear after reset");
  a_addr_write: assert property (
    clk_en_i && addr_wr_i |=> slave_address_o == $past(addr_wdata_i))
    else $error("address write lost");
  a_mask_write: assert property (
    clk_en_i && mask_wr_i |=> slave_address_mask_o == $past(mask_wdata_i))
    else $error("mask write lost");
  a_tx_take: assert property (
    clk_en_i && buf_wr_i && !tx_busy_o |=> tx_busy_o)
    else $error("buffer write not taken");
  a_tx_start_soon: assert property (
    $rose(tx_busy_o) |-> ##[1:200] !txd_o)
    else $error("start bit missing");
  a_tx_idle_high: assert property (
    !tx_busy_o |-> txd_o)
    else $error("line low while idle");
  a_bit_hold: assert property (
    $changed(txd_o) |=> $stable(txd_o) [*8])
    else $error("line level shorter than a bit");
  a_done_after_send: assert property (
    $fell(tx_busy_o) |-> ##[0:2] tx_done_flag_o)
    else $error("transmit done not set");
  a_rx_blocked: assert property (
    rx_done_flag_o && !rx_done_clr_i |=> $stable(rx_frame_o))
    else $error("frame loaded while flag set");
  a_rx_load_flag: assert property (
    $changed(rx_frame_o) |-> $rose(rx_done_flag_o))
    else $error("frame changed without flag");
endmodule

bind uart9_core uart9_core_chk #(.SLOW_DIV(SLOW_DIV)) chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .buf_wr_i(buf_wr_i),
  .addr_wr_i(addr_wr_i), .addr_wdata_i(addr_wdata_i), .mask_wr_i(mask_wr_i),
  .mask_wdata_i(mask_wdata_i), .rx_done_clr_i(rx_done_clr_i), .txd_o(txd_o),
  .rx_frame_o(rx_frame_o), .rx_done_flag_o(rx_done_flag_o), .tx_done_flag_o(tx_done_flag_o),
  .tx_busy_o(tx_busy_o), .slave_address_o(slave_address_o),
  .slave_address_mask_o(slave_address_mask_o));

// ---- sim/uart9_node.sv ----
// Remote serial node: sends frames to the core and captures frames from it.
`timescale 1ns/1ps
module uart9_node (
  // Clock
  input wire logic clk_i,
  // Serial lines
  input wire logic line_i,
  output logic line_o
);
  initial line_o = 1'b1;

  // Start low, byte LSB first, ninth bit, stop high; the line then idles high.
  task automatic send(input logic [7:0] b, input logic n, input int bt);
    logic [10:0] f;
    f = {1'b1, n, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_o = f[i];
      repeat (bt) @(negedge clk_i);
    end
  endtask

  // A low pulse far shorter than a bit, so the start vote must see high.
  task automatic glitch();
    line_o = 1'b0;
    repeat (4) @(negedge clk_i);
    line_o = 1'b1;
    repeat (24) @(negedge clk_i);
  endtask

  // Samples mid-bit on the falling clock edge to stay clear of the output update.
  task automatic recv(output logic [9:0] v, input int bt);
    int k;
    k = 0;
    while (line_i !== 1'b0 && k < 2000) begin
      @(negedge clk_i);
      k++;
    end
    // A missing start bit hands back unknowns so the caller counts a mismatch.
    if (k >= 2000) begin
      v = 'x;
    end else begin
      repeat (bt + bt / 2) @(negedge clk_i);
      for (int i = 0; i < 10; i++) begin
        v[i] = line_i;
        repeat (bt) @(negedge clk_i);
      end
    end
  endtask
endmodule

// ---- sim/uart9_core_tb.sv ----
// Self-checking bench for the nine-bit serial port core.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module uart9_core_tb;
  import uart9_pkg::*;
  logic clk, reset_n, buf_wr, t8, addr_wr, mask_wr, rclr, tclr, rxd, txd;
  logic rdone, tdone, busy, cen;
  logic ovf = 1'b0;
  logic [7:0] wdata, addr_d, mask_d, sa, sm;
  serial_cfg_t cfg;
  rx_frame_t frame;
  int n_errors = 0;
  int n_tests = 0;
  int ovf_cnt = 0;

  uart9_core #(.SLOW_DIV(2)) DUT (
    .clk_i(clk), .reset_n_i(reset_n), .clk_en_i(cen), .cfg_i(cfg), .timer1_ovf_i(ovf),
    .buf_wr_i(buf_wr), .buf_wdata_i(wdata), .tx_ninth_bit_i(t8), .addr_wr_i(addr_wr),
    .addr_wdata_i(addr_d), .mask_wr_i(mask_wr), .mask_wdata_i(mask_d),
    .rx_done_clr_i(rclr), .tx_done_clr_i(tclr), .rxd_i(rxd), .txd_o(txd),
    .rx_frame_o(frame), .rx_done_flag_o(rdone), .tx_done_flag_o(tdone), .tx_busy_o(busy),
    .slave_address_o(sa), .slave_address_mask_o(sm));
  uart9_node node (.clk_i(clk), .line_i(txd), .line_o(rxd));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Timer overflow every third clock gives a 48-clock bit in the variable mode.
  always @(negedge clk) begin
    ovf_cnt <= (ovf_cnt + 1) % 3;
    ovf <= (ovf_cnt == 2);
  end

  task automatic tally_and_finish();
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    reset_n = 1'b0;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(sa, 8'h00)
    `CHK(sm, 8'h00)
    `CHK(txd, 1'b1)
  endtask

  task automatic set_addr(input logic [7:0] a, input logic [7:0] m);
    addr_d = a;
    mask_d = m;
    addr_wr = 1'b1;
    mask_wr = 1'b1;
    @(negedge clk);
    addr_wr = 1'b0;
    mask_wr = 1'b0;
    `CHK(sa, a)
    `CHK(sm, m)
  endtask

  // With the enable low nothing may move, so this write must not land.
  task automatic t_freeze();
    cen = 1'b0;
    addr_d = 8'h3C;
    addr_wr = 1'b1;
    @(negedge clk);
    addr_wr = 1'b0;
    cen = 1'b1;
    `CHK(sa, 8'h00)
  endtask

  // A second write while busy must be ignored, so the line carries the first byte.
  task automatic t_tx(input logic [7:0] b, input logic n, input int bt);
    logic [9:0] got;
    int c;
    fork
      node.recv(got, bt);
      begin
        wdata = b;
        t8 = n;
        buf_wr = 1'b1;
        @(negedge clk);
        buf_wr = 1'b0;
        repeat (3) @(negedge clk);
        wdata = ~b;
        buf_wr = 1'b1;
        @(negedge clk);
        buf_wr = 1'b0;
        c = 5;
        while (tdone !== 1'b1 && c < 12 * bt) begin
          @(negedge clk);
          c++;
        end
      end
    join
    `CHK(c >= 10 * bt && c <= 11 * bt + 2, 1'b1)
    // The ten-bit format sends a stop level in the ninth position.
    `CHK(got, {1'b1, n | cfg.ten_bit, b})
    if (c >= 12 * bt || $isunknown(got)) begin
      tally_and_finish();
    end else begin
      tclr = 1'b1;
      @(negedge clk);
      tclr = 1'b0;
    end
  endtask

  task automatic t_rx(input logic [7:0] b, input logic n, input logic ld, input logic clr);
    rx_frame_t old;
    logic f0;
    int c;
    old = frame;
    f0 = rdone;
    node.send(b, n, 16);
    c = 0;
    while (rdone === f0 && c < 40) begin
      @(negedge clk);
      c++;
    end
    `CHK(rdone, f0 | ld)
    `CHK(frame, ld ? rx_frame_t'({b, n}) : old)
    rclr = clr;
    @(negedge clk);
    rclr = 1'b0;
    // The receiver hunts again only sixteen ticks after its final shift.
    repeat (16) @(negedge clk);
  endtask

  initial begin
    reset_n = 1'b0;
    cfg = serial_cfg_t'(5'h01);
    buf_wr = 1'b0;
    wdata = 8'h00;
    t8 = 1'b0;
    addr_wr = 1'b0;
    mask_wr = 1'b0;
    addr_d = 8'h00;
    mask_d = 8'h00;
    rclr = 1'b0;
    tclr = 1'b0;
    cen = 1'b1;
    do_reset();
    t_freeze();
    t_tx(8'hA5, 1'b1, 16);
    t_tx(8'h5A, 1'b0, 16);
    cfg = serial_cfg_t'(5'h09);
    t_tx(8'hC3, 1'b0, 32);
    cfg = serial_cfg_t'(5'h11);
    t_tx(8'h3C, 1'b1, 48);
    cfg = serial_cfg_t'(5'h05);
    t_tx(8'h81, 1'b0, 16);
    cfg = serial_cfg_t'(5'h01);
    node.glitch();
    t_rx(8'h96, 1'b0, 1'b1, 1'b1);
    t_rx(8'h69, 1'b1, 1'b1, 1'b0);
    t_rx(8'hF0, 1'b1, 1'b0, 1'b1);
    cfg = serial_cfg_t'(5'h03);
    set_addr(8'hC0, 8'hFD);
    t_rx(8'hC2, 1'b0, 1'b0, 1'b1);
    t_rx(8'hC2, 1'b1, 1'b1, 1'b1);
    t_rx(8'hC1, 1'b1, 1'b0, 1'b1);
    t_rx(8'hFF, 1'b1, 1'b1, 1'b1);
    cfg = serial_cfg_t'(5'h07);
    t_rx(8'hC1, 1'b1, 1'b1, 1'b1);
    t_rx(8'hC1, 1'b0, 1'b0, 1'b1);
    cfg = serial_cfg_t'(5'h03);
    do_reset();
    t_rx(8'h5B, 1'b1, 1'b1, 1'b1);
    tally_and_finish();
  end
endmodule
